// [common/sram_host_pkg.sv]
package sram_host_pkg;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 10;
	// slowest-grade cycle and access figures in ns
	localparam int ACCESS_NS = 35;
	localparam int WRITE_PULSE_NS = 25;
	localparam int DATA_SETUP_NS = 15;
	localparam int BUS_TURN_NS = 15;
	localparam int IDLE_POWERDOWN_DELAY_NS = 35;
	// least times round up to whole cycles, at least one
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up
	localparam int ACCESS_CYC = cyc_up(ACCESS_NS) + 1;
	localparam int WRITE_CYC = cyc_up(WRITE_PULSE_NS);
	localparam int SETUP_CYC = cyc_up(DATA_SETUP_NS);
	localparam int TURN_CYC = cyc_up(BUS_TURN_NS);
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC);
	localparam logic [CNT_W-1:0] WRITE_CNT = CNT_W'(WRITE_CYC);
	localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYC);
	localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(TURN_CYC);
	// two-flop read-data synchroniser latency, added to the access wait
	localparam int SYNC_CYC = 2;
	localparam logic [CNT_W-1:0] SYNC_CNT = CNT_W'(SYNC_CYC);
	typedef enum logic [2:0] {IDLE, RD_WAIT, WR_SETUP, WR_PULSE, WR_HOLD, TURN} state_t;
endpackage : sram_host_pkg

// [rtl/sync2.sv]
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for the read-data pins
module sync2 #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;
	// first stage feeds only the second stage
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			dout   <= '0;
		end
		else
		begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule : sync2
`default_nettype wire

// [rtl/sram_host.sv]
`timescale 1ns/10ps
`default_nettype none
// host controller driving an asynchronous dual-select static RAM
// one request at a time; reads answer with a pulse, writes only free the port
module sram_host (
	input  wire logic                              mclk,
	input  wire logic                              rst_n,
	input  wire logic                              reqValid,
	output logic                                   reqReady,
	input  wire logic                              reqWrite,
	input  wire logic [sram_host_pkg::ADDR_W-1:0]  reqAddr,
	input  wire logic [sram_host_pkg::DATA_W-1:0]  reqWdata,
	output logic                                   rspValid,
	output logic      [sram_host_pkg::DATA_W-1:0]  rspRdata,
	output logic      [sram_host_pkg::ADDR_W-1:0]  memAddr,
	output logic                                   selectLowFirst_n,
	output logic                                   selectLowSecond_n,
	output logic                                   writeStrobe_n,
	output logic                                   outputGate_n,
	input  wire logic [sram_host_pkg::DATA_W-1:0]  memDataIn,
	output logic      [sram_host_pkg::DATA_W-1:0]  memDataOut,
	output logic                                   memDataOe
);
	sram_host_pkg::state_t state_r, state_nxt;
	logic [sram_host_pkg::CNT_W-1:0]   cnt_r, cnt_nxt;
	logic [sram_host_pkg::DATA_W-1:0]  rdSync;
	logic                              cntDone;
	logic                              take;
	// next pin levels and the read capture strobe
	logic                              frameNxt;
	logic                              readNxt;
	logic                              strobeNxt;
	logic                              driveNxt;
	logic                              capture;

	////////////////////////////////////////////////////////////////////////
	// read data pins cross from the asynchronous device
	// bits may settle on different edges, but they stand still long before capture
	sync2 #(.W(sram_host_pkg::DATA_W)) u_sync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.din   (memDataIn),
		.dout  (rdSync)
	);

	////////////////////////////////////////////////////////////////////////
	// request handshake only in idle, so the address never moves mid-access
	// no back-to-back takes: ready drops for the whole access and turnaround
	assign cntDone  = (cnt_r == '0);
	assign reqReady = (state_r == sram_host_pkg::IDLE);
	assign take     = reqValid && reqReady;

	////////////////////////////////////////////////////////////////////////
	// state decoding shared by the pin drivers; each pin follows the state
	// being entered, so it moves on the same edge as the state register and
	// the selects, strobe and gate never disagree for a cycle
	function automatic logic frames(input sram_host_pkg::state_t s);
		return (s == sram_host_pkg::RD_WAIT)
			|| (s == sram_host_pkg::WR_SETUP)
			|| (s == sram_host_pkg::WR_PULSE);
	endfunction : frames

	// the strobe window is the write setup and pulse, never the hold cycle
	function automatic logic strobes(input sram_host_pkg::state_t s);
		return (s == sram_host_pkg::WR_SETUP)
			|| (s == sram_host_pkg::WR_PULSE);
	endfunction : strobes

	////////////////////////////////////////////////////////////////////////
	// pin levels for the state being entered
	assign frameNxt  = frames(state_nxt);
	assign readNxt   = (state_nxt == sram_host_pkg::RD_WAIT);
	assign strobeNxt = strobes(state_nxt);
	// the bus stays driven one cycle past the strobe so the data hold is met
	assign driveNxt  = strobes(state_nxt) || (state_nxt == sram_host_pkg::WR_HOLD);
	// the access window closes when the counter runs out in the read wait
	assign capture   = (state_r == sram_host_pkg::RD_WAIT) && cntDone;

	// next-state selection
	// the counter runs down and parks at zero; each transition loads the span of the state it enters
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cntDone ? cnt_r : cnt_r - 1'b1;
		case (state_r)
			// requests are taken only here, with every pin released
			sram_host_pkg::IDLE:
			begin
				if (take && reqWrite)
				begin
					state_nxt = sram_host_pkg::WR_SETUP;
					cnt_nxt   = sram_host_pkg::SETUP_CNT;
				end
				else if (take)
				begin
					// the read data pass two flops, so their delay joins the access wait
					state_nxt = sram_host_pkg::RD_WAIT;
					cnt_nxt   = sram_host_pkg::ACCESS_CNT + sram_host_pkg::SYNC_CNT;
				end
			end
			// selects and gate stay low for the full access plus the sync delay
			sram_host_pkg::RD_WAIT:
				if (cntDone)
				begin
					state_nxt = sram_host_pkg::TURN;
					cnt_nxt   = sram_host_pkg::TURN_CNT;
				end
			// data and address settle under the low strobe before the counted pulse
			sram_host_pkg::WR_SETUP:
				if (cntDone)
				begin
					state_nxt = sram_host_pkg::WR_PULSE;
					cnt_nxt   = sram_host_pkg::WRITE_CNT;
				end
			// the counted pulse is the part of the overlap that meets the write width
			sram_host_pkg::WR_PULSE:
				if (cntDone)
				begin
					state_nxt = sram_host_pkg::WR_HOLD;
					cnt_nxt   = 4'h0;
				end
			// strobe and selects are high again; the bus is still driven
			sram_host_pkg::WR_HOLD:
				state_nxt = sram_host_pkg::IDLE;
			// lets the device release the bus before a following write drives it
			sram_host_pkg::TURN:
				if (cntDone)
					state_nxt = sram_host_pkg::IDLE;
			// an unreachable code falls back to idle with every pin released
			default:
				state_nxt = sram_host_pkg::IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// state and counter
	// reset returns to idle with the counter parked at zero
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_r <= sram_host_pkg::IDLE;
			cnt_r   <= 4'h0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address and write data load only on a take, which happens in idle with
	// both selects high, so the address never moves under a framed access
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			memAddr    <= '0;
			memDataOut <= '0;
		end
		else if (take)
		begin
			memAddr    <= reqAddr;
			memDataOut <= reqWdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// selects and output gate are registered so no glitch reaches the part;
	// both selects move together, so one edge frames every access
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			selectLowFirst_n  <= 1'b1;
			selectLowSecond_n <= 1'b1;
			outputGate_n      <= 1'b1;
		end
		else
		begin
			selectLowFirst_n  <= !frameNxt;
			selectLowSecond_n <= !frameNxt;
			outputGate_n      <= !readNxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write strobe and bus enable; the strobe falls with the selects and
	// rises with them, so the device never drives read data at write end,
	// while the bus is kept one cycle longer for the data hold
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			writeStrobe_n <= 1'b1;
			memDataOe     <= 1'b0;
		end
		else
		begin
			writeStrobe_n <= !strobeNxt;
			memDataOe     <= driveNxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data captured at the end of the access window
	// the word holds until the next read, so a slow consumer may take it late
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rspValid <= 1'b0;
			rspRdata <= '0;
		end
		else
		begin
			rspValid <= capture;
			if (capture)
				rspRdata <= rdSync;
		end
	end
endmodule : sram_host
`default_nettype wire

// [test/sram_host_sva.sv]
`timescale 1ns/10ps
`default_nettype none
// pin-level checks on the host side of the static RAM interface
module sram_host_sva (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [13:0] memAddr,
	input wire logic        selectLowFirst_n,
	input wire logic        selectLowSecond_n,
	input wire logic        writeStrobe_n,
	input wire logic        outputGate_n,
	input wire logic [7:0]  memDataOut,
	input wire logic        memDataOe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// both selects low: the device is framed
	wire logic sel = !selectLowFirst_n && !selectLowSecond_n;
	////////////////////////////////////////////////////////////////
	a_read_strobe_high: assert property (!outputGate_n |-> writeStrobe_n)
		else $error("strobe low while output gate open");
	a_wdata_steady: assert property (!writeStrobe_n && $past(!writeStrobe_n) |-> memDataOe && $stable(memDataOut))
		else $error("write data moved inside strobe");
	a_write_hold: assert property ($rose(writeStrobe_n) |-> memDataOe && $stable(memDataOut) && $stable(memAddr))
		else $error("no hold after write end");
	a_addr_when_idle: assert property ($changed(memAddr) |-> $past(writeStrobe_n) || $past(selectLowFirst_n))
		else $error("address moved while framed");
	a_addr_steady_sel: assert property (sel && $past(sel) |-> $stable(memAddr))
		else $error("address moved under low selects");
	a_selects_paired: assert property (selectLowFirst_n == selectLowSecond_n)
		else $error("selects split");
	c_write_end: cover property ($rose(writeStrobe_n));
	c_read_end: cover property ($rose(outputGate_n));
	c_select_fall: cover property ($fell(selectLowFirst_n));
endmodule : sram_host_sva
bind sram_host sram_host_sva i_sram_host_sva (.mclk, .rst_n, .memAddr, .selectLowFirst_n,
	.selectLowSecond_n, .writeStrobe_n, .outputGate_n, .memDataOut, .memDataOe);
`default_nettype wire

// [test/sram_model.sv]
`timescale 1ns/10ps
`default_nettype none
// behavioural dual-select static RAM; no access timing, standby state tracked
module sram_model (
	input wire logic [13:0] memAddr,
	input wire logic        selectLowFirst_n,
	input wire logic        selectLowSecond_n,
	input wire logic        writeStrobe_n,
	input wire logic        outputGate_n,
	input wire logic [7:0]  memDataOut,
	input wire logic        memDataOe,
	output logic     [7:0]  memDataIn
);
	logic [7:0] store [0:16383];
	// write needs all three low; read output needs strobe high and gate low
	wire logic writing = !selectLowFirst_n && !selectLowSecond_n && !writeStrobe_n;
	wire logic driving = !selectLowFirst_n && !selectLowSecond_n && writeStrobe_n && !outputGate_n;
	////////////////////////////////////////////////////////////////
	// commit on the first rising framing signal, same polarity as read back
	always @(negedge writing) store[memAddr] <= memDataOut;
	// floating lines show the inverse so a stale value never passes
	always_comb memDataIn = memDataOe ? memDataOut : driving ? store[memAddr] : ~store[memAddr];
	// standby tracker: framed activity wakes the part, which drops back a fixed
	// delay after the last wake, so power follows access rate, not select width
	logic awake = 1'b0;
	int   wakeSeq = 0;
	int   sleepSeq = 0;
	always @(negedge selectLowFirst_n, negedge selectLowSecond_n, negedge writeStrobe_n,
		memAddr, memDataOut)
		if (!selectLowFirst_n && !selectLowSecond_n)
		begin
			wakeSeq++;
			awake = 1'b1;
			sleepSeq <= #(sram_host_pkg::IDLE_POWERDOWN_DELAY_NS) wakeSeq;
		end
	always @(sleepSeq)
		if (sleepSeq == wakeSeq)
			awake = 1'b0;
endmodule : sram_model
`default_nettype wire

// [test/dual_select_sram_control_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module dual_select_sram_control_bench;
	logic        mclk, rst_n, reqValid, reqReady, reqWrite, rspValid, memDataOe;
	logic        selectLowFirst_n, selectLowSecond_n, writeStrobe_n, outputGate_n;
	logic [13:0] reqAddr, memAddr;
	logic [7:0]  reqWdata, rspRdata, memDataIn, memDataOut;
	logic [22:0] rows [8];
	int          mismatches, num_checks;
	sram_host i_sram_host (.mclk, .rst_n, .reqValid, .reqReady, .reqWrite, .reqAddr, .reqWdata,
		.rspValid, .rspRdata, .memAddr, .selectLowFirst_n, .selectLowSecond_n, .writeStrobe_n,
		.outputGate_n, .memDataIn, .memDataOut, .memDataOe);
	sram_model i_sram_model (.memAddr, .selectLowFirst_n, .selectLowSecond_n, .writeStrobe_n,
		.outputGate_n, .memDataOut, .memDataOe, .memDataIn);
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one request, held until taken; reads wait for the answer, bounded
	task automatic req(input logic w, input logic [13:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (reqReady !== 1'b1 && n < 40)
		begin
			@(posedge mclk);
			#1 n++;
		end
		{reqValid, reqWrite, reqAddr, reqWdata} = {1'b1, w, a, d};
		@(posedge mclk);
		#1 reqValid = 1'b0;
		// one budget covers the wait for ready and the wait for the answer
		while (!w && rspValid !== 1'b1 && n < 40)
		begin
			@(posedge mclk);
			#1 n++;
		end
		if (n >= 40)
		begin
			mismatches++;
			$display("Error at %0t: request not served in time", $time);
		end
	endtask : req
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	initial
	begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	// watchdog: the whole sequence needs about 1.3 us
	initial
	begin
		#20000 mismatches++;
		summarize();
	end
	initial
	begin
		{rst_n, reqValid, reqWrite, reqAddr, reqWdata} = '0;
		rows = '{23'h4000A5, 23'h7FFF5A, 23'h555500, 23'h6AAAFF,
			23'h0000A5, 23'h3FFF5A, 23'h155500, 23'h2AAAFF};
		repeat (8) @(posedge mclk);
		#1 rst_n = 1'b1;
		chk({selectLowFirst_n, selectLowSecond_n, writeStrobe_n, outputGate_n, memDataOe,
			reqReady}, 16'h003D);
		// table: writes to edge and alternating-bit addresses, then read back each
		for (int i = 0; i < 8; i++)
		begin
			req(rows[i][22], rows[i][21:8], rows[i][7:0]);
			if (!rows[i][22])
				chk(rspRdata, rows[i][7:0]);
			$display("test %0d done", i);
		end
		// overwrite and read straight back at the first ready
		req(1'b1, 14'h2AAA, 8'h3C);
		req(1'b0, 14'h2AAA, 8'h00);
		chk(rspRdata, 16'h003C);
		chk(i_sram_model.awake, 16'h0000);
		$display("test overwrite done");
		// reset in mid-read leaves the pins idle and the store intact
		repeat (3) @(posedge mclk);
		#1 chk(reqReady, 16'h0001);
		{reqValid, reqAddr} = {1'b1, 14'h3FFF};
		@(posedge mclk);
		#1 reqValid = 1'b0;
		chk(i_sram_model.awake, 16'h0001);
		repeat (3) @(posedge mclk);
		#1 rst_n = 1'b0;
		@(posedge mclk);
		#1 rst_n = 1'b1;
		chk({selectLowFirst_n, selectLowSecond_n, outputGate_n, memDataOe}, 16'h000E);
		req(1'b0, 14'h0000, 8'h00);
		chk(rspRdata, 16'h00A5);
		$display("test reset done");
		summarize();
	end
endmodule : dual_select_sram_control_bench
`default_nettype wire
